// file: logic/prri_top.sv
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "prri_defs.svh"

// Summary of operation
// - TIM enable in control 2 bit 4 sends TIM code on TIM declaration.
// - UNEQ enable in control 2 sends UNEQ code on UNEQ declaration.
// - Control 3 bits 7 to 5 hold the LCD code sent on LCD.
// - Control 3 bit 4 enables LCD code; clear means LCD is ignored.
// - Source select field bits 4 and 3 value 01 picks software mode.
// - Software mode copies G1 value bits 3 to 1 into outbound G1 bits.
// - Source select value 10 picks the external serial port.
// - External mode sends the serially received bits, replacing internal ones.
// - Device latches each serial bit on the following rising edge.
// - First external bit is taken as outbound bit 2, where software mode puts G1 value bit 3.
module prri_top
(
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         wb_cyc_i,
   input  wire logic         wb_stb_i,
   input  wire logic         wb_we_i,
   input  wire logic [7:0]   wb_adr_i,
   input  wire logic [3:0]   wb_sel_i,
   input  wire logic [31:0]  wb_dat_i,
   output logic      [31:0]  wb_dat_o,
   output logic              wb_ack_o,
   input  wire logic         tim_declared_i,
   input  wire logic         uneq_declared_i,
   input  wire logic         lcd_declared_i,
   input  wire logic         plm_declared_i,
   input  wire logic         serial_overhead_data_in_i,
   input  wire logic         overhead_insert_strobe_in_i,
   output logic              overhead_serial_clock_out_o,
   output logic              overhead_slot_enable_out_o,
   output logic              overhead_frame_mark_out_o,
   output logic      [2:0]   rdi_bits_o,
   output logic              rdi_update_o
);

   localparam logic [2:0] DIV_LAST  = 3'(`PRRI_OHCLK_DIV - 1);
   localparam logic [2:0] DIV_HALF  = 3'(`PRRI_OHCLK_HALF);
   localparam logic [6:0] SLOT_LAST = 7'(`PRRI_FRAME_SLOTS - 1);
   localparam logic [6:0] SLOT_WAIT = 7'(`PRRI_WAIT_PERIODS);
   localparam logic [6:0] SLOT_END  = 7'(`PRRI_FIRST_SLOT + `PRRI_RDI_BITS - 1);

   logic [7:0]                   ctrl1_r;
   logic [7:0]                   ctrl2_r;
   logic [7:0]                   ctrl3_r;
   logic [7:0]                   txctrl_r;
   logic [7:0]                   g1val_r;
   logic                         ack_r;
   logic [31:0]                  rdata_r;
   logic [7:0]                   rdata_nxt;
   logic                         wr_en;
   logic                         req;

   logic [1:0]                   sdata_sync_r;
   logic [1:0]                   ins_sync_r;

   logic [2:0]                   div_r;
   logic                         ohclk_r;
   logic                         rise_tick;
   logic                         fall_tick;
   logic [6:0]                   slot_r;
   prri_pkg::prri_port_state_e   state_r;
   prri_pkg::prri_port_state_e   state_nxt;
   logic                         enable_r;
   logic                         frame_r;
   logic [2:0]                   ext_bits_r;
   logic [2:0]                   rdi_r;
   logic                         upd_r;
   prri_pkg::prri_code_t         rdi_nxt;
   prri_pkg::prri_src_e          src_sel;

   assign req   = wb_cyc_i && wb_stb_i;
   // Write lands on the edge where the master sees ack, while it still holds the data
   assign wr_en = req && wb_we_i && ack_r && wb_sel_i[0];

   // Bus answer one cycle after the request; dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= req && !ack_r;
      end
   end

   // Register writes; only byte lane 0 holds data
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ctrl1_r  <= `PRRI_RST_CTRL;
         ctrl2_r  <= `PRRI_RST_CTRL;
         ctrl3_r  <= `PRRI_RST_CTRL;
         txctrl_r <= `PRRI_RST_CTRL;
         g1val_r  <= `PRRI_RST_G1VAL;
      end
      else if (wr_en)
      begin
         case ({wb_adr_i[7:2], 2'b00})
            `PRRI_OFS_CTRL1:  ctrl1_r  <= wb_dat_i[7:0];
            `PRRI_OFS_CTRL2:  ctrl2_r  <= wb_dat_i[7:0];
            `PRRI_OFS_CTRL3:  ctrl3_r  <= wb_dat_i[7:0];
            `PRRI_OFS_TXCTRL: txctrl_r <= wb_dat_i[7:0];
            `PRRI_OFS_G1VAL:  g1val_r  <= wb_dat_i[7:0];
            default:          ctrl1_r  <= ctrl1_r;
         endcase
      end
   end

   // Unmapped addresses read zero and ignore writes
   always_comb
   begin
      case ({wb_adr_i[7:2], 2'b00})
         `PRRI_OFS_CTRL1:  rdata_nxt = ctrl1_r;
         `PRRI_OFS_CTRL2:  rdata_nxt = ctrl2_r;
         `PRRI_OFS_CTRL3:  rdata_nxt = ctrl3_r;
         `PRRI_OFS_TXCTRL: rdata_nxt = txctrl_r;
         `PRRI_OFS_G1VAL:  rdata_nxt = g1val_r;
         `PRRI_OFS_STATUS: rdata_nxt = {rdi_r, ins_sync_r[1], tim_declared_i,
                                        uneq_declared_i, lcd_declared_i, plm_declared_i};
         default:          rdata_nxt = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_r <= 32'h00000000;
      end
      else if (req && !ack_r)
      begin
         rdata_r <= {24'h000000, rdata_nxt};
      end
   end

   assign wb_dat_o = rdata_r;
   assign wb_ack_o = ack_r;

   // Serial data and insert strobe inputs pass two flops before use; defect inputs are used directly
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sdata_sync_r <= 2'h0;
         ins_sync_r   <= 2'h0;
      end
      else
      begin
         sdata_sync_r <= {sdata_sync_r[0], serial_overhead_data_in_i};
         ins_sync_r   <= {ins_sync_r[0], overhead_insert_strobe_in_i};
      end
   end

   // Overhead clock made by dividing the system clock
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         div_r   <= 3'h0;
         ohclk_r <= 1'b0;
      end
      else
      begin
         div_r <= (div_r == DIV_LAST) ? 3'h0 : div_r + 3'h1;
         if (div_r == DIV_LAST)
         begin
            ohclk_r <= 1'b1;
         end
         else if (div_r == DIV_HALF - 3'h1)
         begin
            ohclk_r <= 1'b0;
         end
      end
   end

   assign rise_tick = (div_r == DIV_LAST);
   assign fall_tick = (div_r == DIV_HALF - 3'h1);
   assign overhead_serial_clock_out_o = ohclk_r;

   // Slot count steps on falling edges so outputs settle before the rise
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         slot_r <= 7'h00;
      end
      else if (fall_tick)
      begin
         slot_r <= (slot_r == SLOT_LAST) ? 7'h00 : slot_r + 7'h01;
      end
   end

   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         prri_pkg::PRRI_ST_MARK:
         begin
            state_nxt = prri_pkg::PRRI_ST_WAIT;
         end
         prri_pkg::PRRI_ST_WAIT:
         begin
            if (slot_r == SLOT_WAIT)
            begin
               state_nxt = prri_pkg::PRRI_ST_BITS;
            end
         end
         prri_pkg::PRRI_ST_BITS:
         begin
            if (slot_r == SLOT_END)
            begin
               state_nxt = prri_pkg::PRRI_ST_REST;
            end
         end
         prri_pkg::PRRI_ST_REST:
         begin
            if (slot_r == SLOT_LAST)
            begin
               state_nxt = prri_pkg::PRRI_ST_MARK;
            end
         end
         default:
         begin
            state_nxt = prri_pkg::PRRI_ST_MARK;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= prri_pkg::PRRI_ST_MARK;
      end
      else if (fall_tick)
      begin
         state_r <= state_nxt;
      end
   end

   // Enable stays high in every slot from the first falling tick on; frame marks only slot 0 of each frame
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         enable_r <= 1'b0;
         frame_r  <= 1'b0;
      end
      else if (fall_tick)
      begin
         enable_r <= 1'b1;
         frame_r  <= (slot_r == SLOT_LAST);
      end
   end

   assign overhead_slot_enable_out_o = enable_r;
   assign overhead_frame_mark_out_o  = frame_r;

   // Capture on the rise after the bit was presented; first bit ends in outbound bit 2
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ext_bits_r <= 3'h0;
      end
      else if (rise_tick && state_r == prri_pkg::PRRI_ST_BITS)
      begin
         ext_bits_r <= {ext_bits_r[1:0], sdata_sync_r[1]};
      end
   end

   assign src_sel = prri_pkg::prri_src_e'(txctrl_r[`PRRI_SRC_HI:`PRRI_SRC_LO]);

   // Fixed priority among defects keeps the code stable when several overlap
   always_comb
   begin
      rdi_nxt = 3'h0;
      case (src_sel)
         prri_pkg::PRRI_SRC_SOFT:
         begin
            rdi_nxt = g1val_r[`PRRI_G1VAL_HI:`PRRI_G1VAL_LO];
         end
         prri_pkg::PRRI_SRC_EXT:
         begin
            rdi_nxt = ext_bits_r;
         end
         default:
         begin
            if (ctrl2_r[`PRRI_EN_A_BIT] && tim_declared_i)
            begin
               rdi_nxt = ctrl2_r[`PRRI_CODE_A_HI:`PRRI_CODE_A_LO];
            end
            else if (ctrl2_r[`PRRI_EN_B_BIT] && uneq_declared_i)
            begin
               rdi_nxt = ctrl2_r[`PRRI_CODE_B_HI:`PRRI_CODE_B_LO];
            end
            else if (ctrl3_r[`PRRI_EN_A_BIT] && lcd_declared_i)
            begin
               rdi_nxt = ctrl3_r[`PRRI_CODE_A_HI:`PRRI_CODE_A_LO];
            end
            else if (ctrl3_r[`PRRI_EN_B_BIT] && plm_declared_i)
            begin
               rdi_nxt = ctrl3_r[`PRRI_CODE_B_HI:`PRRI_CODE_B_LO];
            end
         end
      endcase
   end

   // Outbound bits change only at the frame boundary, once per SPE
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdi_r <= 3'h0;
         upd_r <= 1'b0;
      end
      else
      begin
         upd_r <= fall_tick && (slot_r == SLOT_LAST);
         if (fall_tick && slot_r == SLOT_LAST)
         begin
            rdi_r <= rdi_nxt;
         end
      end
   end

   assign rdi_bits_o   = rdi_r;
   assign rdi_update_o = upd_r;

endmodule

// file: logic/prri_defs.svh
`ifndef PRRI_DEFS_SVH
`define PRRI_DEFS_SVH
// Register word offsets (byte addresses)
`define PRRI_OFS_CTRL1      8'h00
`define PRRI_OFS_CTRL2      8'h04
`define PRRI_OFS_CTRL3      8'h08
`define PRRI_OFS_TXCTRL     8'h0C
`define PRRI_OFS_G1VAL      8'h10
`define PRRI_OFS_STATUS     8'h14
// Reset values
`define PRRI_RST_CTRL       8'h00
`define PRRI_RST_G1VAL      8'h00
// Field positions
`define PRRI_CODE_A_HI      7
`define PRRI_CODE_A_LO      5
`define PRRI_EN_A_BIT       4
`define PRRI_CODE_B_HI      3
`define PRRI_CODE_B_LO      1
`define PRRI_EN_B_BIT       0
`define PRRI_SRC_HI         4
`define PRRI_SRC_LO         3
`define PRRI_G1VAL_HI       3
`define PRRI_G1VAL_LO       1
// Timing
`define PRRI_CLK_NS         100
`define PRRI_OHCLK_NS       800
`define PRRI_OHCLK_DIV      (`PRRI_OHCLK_NS / `PRRI_CLK_NS)
`define PRRI_OHCLK_HALF     (`PRRI_OHCLK_DIV / 2)
`define PRRI_FRAME_SLOTS    72
`define PRRI_WAIT_PERIODS   25
`define PRRI_FIRST_SLOT     (`PRRI_WAIT_PERIODS + 1)
`define PRRI_RDI_BITS       3
`endif

// file: logic/prri_pkg.sv
package prri_pkg;
   typedef enum logic [1:0] {
      PRRI_SRC_AUTO  = 2'h0,
      PRRI_SRC_SOFT  = 2'h1,
      PRRI_SRC_EXT   = 2'h2,
      PRRI_SRC_RSVD  = 2'h3
   } prri_src_e;

   typedef enum logic [3:0] {
      PRRI_ST_MARK   = 4'h1,
      PRRI_ST_WAIT   = 4'h2,
      PRRI_ST_BITS   = 4'h4,
      PRRI_ST_REST   = 4'h8
   } prri_port_state_e;

   typedef logic [2:0] prri_code_t;
endpackage

// file: bench/prri_properties.sv
`timescale 1ns/100ps
module prri_properties
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        overhead_serial_clock_out_o,
   input wire logic        overhead_slot_enable_out_o,
   input wire logic        overhead_frame_mark_out_o,
   input wire logic [2:0]  rdi_bits_o,
   input wire logic        rdi_update_o
);
   logic [9:0] gap_r;
   logic       seen_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // First mark after reset has no earlier mark to measure from
   always_ff @(posedge clk_i)
      gap_r <= (rst_i || $rose(overhead_frame_mark_out_o)) ? 10'h001 : gap_r + 10'h001;
   always_ff @(posedge clk_i)
      seen_r <= !rst_i && (seen_r || $rose(overhead_frame_mark_out_o));

   a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered next cycle");
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_unmapped_reads_zero: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
      && wb_adr_i[7:2] > 6'h05 |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   a_ohclk_shape: assert property ($rose(overhead_serial_clock_out_o) |->
      overhead_serial_clock_out_o[*4] ##1 !overhead_serial_clock_out_o[*4] ##1 overhead_serial_clock_out_o)
      else $error("overhead clock not 4 high 4 low");
   a_frame_width: assert property ($rose(overhead_frame_mark_out_o) |->
      overhead_frame_mark_out_o[*8] ##1 !overhead_frame_mark_out_o)
      else $error("frame mark not one overhead period");
   a_frame_on_fall: assert property ($rose(overhead_frame_mark_out_o) |->
      $fell(overhead_serial_clock_out_o))
      else $error("frame mark not on clock fall");
   a_frame_spacing: assert property ($rose(overhead_frame_mark_out_o) && seen_r |->
      gap_r == 10'd576)
      else $error("frame period wrong");
   a_rdi_flagged: assert property (!$stable(rdi_bits_o) |-> rdi_update_o)
      else $error("rdi change without update pulse");
   a_frame_has_enable: assert property (overhead_frame_mark_out_o |-> overhead_slot_enable_out_o)
      else $error("frame mark without slot enable");
endmodule

bind prri_top prri_properties u_props
(
   .clk_i                       (clk_i),
   .rst_i                       (rst_i),
   .wb_cyc_i                    (wb_cyc_i),
   .wb_stb_i                    (wb_stb_i),
   .wb_we_i                     (wb_we_i),
   .wb_adr_i                    (wb_adr_i),
   .wb_dat_o                    (wb_dat_o),
   .wb_ack_o                    (wb_ack_o),
   .overhead_serial_clock_out_o (overhead_serial_clock_out_o),
   .overhead_slot_enable_out_o  (overhead_slot_enable_out_o),
   .overhead_frame_mark_out_o   (overhead_frame_mark_out_o),
   .rdi_bits_o                  (rdi_bits_o),
   .rdi_update_o                (rdi_update_o)
);

// file: bench/prri_far_model.sv
`timescale 1ns/100ps
module prri_far_model
(
   input  wire logic       oh_clk_i,
   input  wire logic       oh_en_i,
   input  wire logic       oh_frame_i,
   input  wire logic [2:0] code_i,
   output logic            data_o
);
   initial data_o = 1'b0;
   always @(posedge oh_clk_i)
   begin
      if (oh_en_i && oh_frame_i)
      begin
         repeat (25) @(posedge oh_clk_i);
         for (int i = 2; i >= 0; i--)
         begin
            @(negedge oh_clk_i);
            data_o <= code_i[i];
         end
         @(negedge oh_clk_i);
         // Hold over: invert so a late sample cannot pass by luck
         data_o <= ~data_o;
      end
   end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   localparam logic [7:0] MSK [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h18, 8'h0E};
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rdi_update_o;
   logic        tim_declared_i, uneq_declared_i, lcd_declared_i, plm_declared_i;
   logic        serial_overhead_data_in_i, overhead_insert_strobe_in_i;
   logic        overhead_serial_clock_out_o, overhead_slot_enable_out_o;
   logic        overhead_frame_mark_out_o;
   logic [7:0]  wb_adr_i, rd, c2, c3, g, r;
   logic [3:0]  wb_sel_i, d;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [2:0]  rdi_bits_o, ext_code;
   logic [1:0]  m;
   int          fail_count, n_compared;

   prri_top DUT
   (
      .clk_i                       (clk_i),
      .rst_i                       (rst_i),
      .wb_cyc_i                    (wb_cyc_i),
      .wb_stb_i                    (wb_stb_i),
      .wb_we_i                     (wb_we_i),
      .wb_adr_i                    (wb_adr_i),
      .wb_sel_i                    (wb_sel_i),
      .wb_dat_i                    (wb_dat_i),
      .wb_dat_o                    (wb_dat_o),
      .wb_ack_o                    (wb_ack_o),
      .tim_declared_i              (tim_declared_i),
      .uneq_declared_i             (uneq_declared_i),
      .lcd_declared_i              (lcd_declared_i),
      .plm_declared_i              (plm_declared_i),
      .serial_overhead_data_in_i   (serial_overhead_data_in_i),
      .overhead_insert_strobe_in_i (overhead_insert_strobe_in_i),
      .overhead_serial_clock_out_o (overhead_serial_clock_out_o),
      .overhead_slot_enable_out_o  (overhead_slot_enable_out_o),
      .overhead_frame_mark_out_o   (overhead_frame_mark_out_o),
      .rdi_bits_o                  (rdi_bits_o),
      .rdi_update_o                (rdi_update_o)
   );
   prri_far_model u_far
   (
      .oh_clk_i   (overhead_serial_clock_out_o),
      .oh_en_i    (overhead_slot_enable_out_o),
      .oh_frame_i (overhead_frame_mark_out_o),
      .code_i     (ext_code),
      .data_o     (serial_overhead_data_in_i)
   );

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         fail_count++;
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] v,
                     input logic [3:0] s);
      @(posedge clk_i);
      // Slave must have dropped ack again before a new request starts
      chk("ack idle", {7'h00, wb_ack_o}, 8'h00);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'h3, we, a, s};
      wb_dat_i <= {24'h000000, v};
      do @(posedge clk_i); while (!wb_ack_o);
      rd = wb_dat_o[7:0];
      {wb_cyc_i, wb_stb_i} <= 2'h0;
   endtask

   task automatic wait_upd();
      int n;
      n = 0;
      do @(posedge clk_i); while (!rdi_update_o && ++n < 800);
      chk("update", {7'h00, rdi_update_o}, 8'h01);
   endtask

   // Auto priority: TIM, UNEQ, LCD, PLM; a disabled cause is skipped
   function automatic logic [2:0] exp_rdi();
      case (m)
         2'h1: return g[3:1];
         2'h2: return ext_code;
         default: return (d[3] && c2[4]) ? c2[7:5] : (d[2] && c2[0]) ? c2[3:1] :
                         (d[1] && c3[4]) ? c3[7:5] : (d[0] && c3[0]) ? c3[3:1] : 3'h0;
      endcase
   endfunction

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial
   begin
      #4000000;
      fail_count++;
      tally_and_finish();
   end

   initial
   begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 48'h800000000000;
      {tim_declared_i, uneq_declared_i, lcd_declared_i, plm_declared_i} = 4'h0;
      overhead_insert_strobe_in_i = 1'b0;
      ext_code = 3'h0;
      void'($urandom(76255));
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         wb(1'b0, 8'(i * 4), 8'h00, 4'hF);
         chk("reset value", rd, 8'h00);
      end
      for (int i = 0; i < 5; i++)
      begin
         r = 8'($urandom);
         wb(1'b1, 8'(i * 4), r, 4'hF);
         wb(1'b0, 8'(i * 4), 8'h00, 4'hF);
         chk("readback", rd & MSK[i], r & MSK[i]);
      end
      wb(1'b1, 8'h00, 8'h3C, 4'hF);
      wb(1'b1, 8'h00, 8'hC3, 4'h0);
      wb(1'b0, 8'h00, 8'h00, 4'hF);
      chk("masked write", rd, 8'h3C);
      wb(1'b1, 8'h18, 8'hFF, 4'hF);
      wb(1'b0, 8'h18, 8'h00, 4'hF);
      chk("unmapped", rd, 8'h00);
      for (int k = 0; k < 12; k++)
      begin
         m = 2'(k);
         c2 = 8'($urandom);
         c3 = 8'($urandom);
         g = (k == 5) ? 8'h00 : 8'($urandom);
         d = 4'($urandom);
         ext_code <= 3'($urandom);
         if (k == 4)
         begin
            c3 = 8'hE0;
            d = 4'h2;
         end
         wb(1'b1, 8'h04, c2, 4'hF);
         wb(1'b1, 8'h08, c3, 4'hF);
         wb(1'b1, 8'h10, g, 4'hF);
         wb(1'b1, 8'h0C, {3'h0, m, 3'h0}, 4'hF);
         {tim_declared_i, uneq_declared_i, lcd_declared_i, plm_declared_i} <= d;
         overhead_insert_strobe_in_i <= 1'($urandom);
         wait_upd();
         wait_upd();
         chk("rdi bits", {5'h00, rdi_bits_o}, {5'h00, exp_rdi()});
         wb(1'b0, 8'h14, 8'h00, 4'hF);
         chk("status", rd, {exp_rdi(), overhead_insert_strobe_in_i, d});
      end
      tally_and_finish();
   end
endmodule
